// ===== hdl/tx_stats_counters.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tx_stats_counters
  import tx_stats_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  tx_events_t       tx_events,
  output tx_counts_t       tx_counts,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire addr_t       s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire count_t      s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output resp_t            s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire addr_t       s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output count_t           s_axi_rdata,
  output resp_t            s_axi_rresp
);

  // event counters

  logic [NUM_CNT-1:0] inc_vec;
  count_t             cnt [NUM_CNT];

  // events share the bus clock, so each pulse is counted once
  always_comb begin
    inc_vec                = '0;
    inc_vec[SLOT_FRAMES]   = tx_events.frame_sent;
    inc_vec[SLOT_BYTES]    = tx_events.byte_sent;
    inc_vec[SLOT_GOOD]     = tx_events.good_byte_sent;
    inc_vec[SLOT_UNDERRUN] = tx_events.underrun_abort;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      event_counter u_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (inc_vec[gi]),
        .count   (cnt[gi])
      );
    end
  endgenerate

  always_comb begin
    tx_counts.frames_sent_bits     = cnt[SLOT_FRAMES];
    tx_counts.bytes_sent_bits      = cnt[SLOT_BYTES];
    tx_counts.good_bytes_sent_bits = cnt[SLOT_GOOD];
    tx_counts.underrun_abort_bits  = cnt[SLOT_UNDERRUN];
  end

  // indirect byte window

  ind_addr_t ind_addr_r;
  byte_t     ind_byte;
  logic      ind_hit;
  count_t    ind_word;
  logic [1:0] ind_lane;

  // word at the indexed location, byte 0 of a word is bits 31:24
  always_comb begin
    ind_word = COUNT_RESET;
    ind_hit  = 1'b0;
    ind_lane = ind_addr_r[1:0];
    if (ind_addr_r[IND_W-1:WORD_LSB] ==
        FRAMES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]) begin
      ind_word = cnt[SLOT_FRAMES];
      ind_hit  = 1'b1;
    end else if (ind_addr_r[IND_W-1:WORD_LSB] ==
                 BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]) begin
      ind_word = cnt[SLOT_BYTES];
      ind_hit  = 1'b1;
    end else if (ind_addr_r[IND_W-1:WORD_LSB] ==
                 GOOD_BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]) begin
      ind_word = cnt[SLOT_GOOD];
      ind_hit  = 1'b1;
    end else if (ind_addr_r[IND_W-1:WORD_LSB] ==
                 UNDERRUN_ABORT_COUNT_OFS[ADDR_W-1:WORD_LSB]) begin
      ind_word = cnt[SLOT_UNDERRUN];
      ind_hit  = 1'b1;
    end
  end

  // most significant byte at the lowest location
  always_comb begin
    case (ind_lane)
      2'h0:    ind_byte = ind_word[31:24];
      2'h1:    ind_byte = ind_word[23:16];
      2'h2:    ind_byte = ind_word[15:8];
      2'h3:    ind_byte = ind_word[7:0];
      default: ind_byte = 8'h00;
    endcase
  end

  // write channel

  logic   aw_held_r;
  addr_t  aw_addr_r;
  logic   w_held_r;
  count_t w_data_r;
  logic [3:0] w_strb_r;
  logic   bvalid_r;
  resp_t  bresp_r;
  logic   wr_go;
  logic   wr_ind_addr;
  resp_t  wr_resp;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // counters accept writes silently, unknown words answer slverr
  always_comb begin
    wr_ind_addr = 1'b0;
    wr_resp     = RESP_OKAY;
    case (aw_addr_r[ADDR_W-1:WORD_LSB])
      IND_ADDR_OFS[ADDR_W-1:WORD_LSB]: wr_ind_addr = 1'b1;
      IND_DATA_OFS[ADDR_W-1:WORD_LSB]: wr_resp = RESP_OKAY;
      FRAMES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        wr_resp = RESP_OKAY;
      BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        wr_resp = RESP_OKAY;
      GOOD_BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        wr_resp = RESP_OKAY;
      UNDERRUN_ABORT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        wr_resp = RESP_OKAY;
      default: wr_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_addr_r <= IND_ADDR_RESET;
    end else if (wr_go && wr_ind_addr) begin
      if (w_strb_r[0]) begin
        ind_addr_r[7:0] <= w_data_r[7:0];
      end
      if (w_strb_r[1]) begin
        ind_addr_r[IND_W-1:8] <= w_data_r[IND_W-1:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // read channel

  logic   rvalid_r;
  count_t rdata_r;
  resp_t  rresp_r;
  count_t rd_data;
  resp_t  rd_resp;

  assign s_axi_arready = !rvalid_r;

  // plain reads never touch the counters
  always_comb begin
    rd_data = COUNT_RESET;
    rd_resp = RESP_OKAY;
    case (s_axi_araddr[ADDR_W-1:WORD_LSB])
      FRAMES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        rd_data = cnt[SLOT_FRAMES];
      BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        rd_data = cnt[SLOT_BYTES];
      GOOD_BYTES_SENT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        rd_data = cnt[SLOT_GOOD];
      UNDERRUN_ABORT_COUNT_OFS[ADDR_W-1:WORD_LSB]:
        rd_data = cnt[SLOT_UNDERRUN];
      IND_ADDR_OFS[ADDR_W-1:WORD_LSB]:
        rd_data[IND_W-1:0] = ind_addr_r;
      IND_DATA_OFS[ADDR_W-1:WORD_LSB]: begin
        rd_data[7:0]         = ind_byte;
        rd_data[IND_HIT_BIT] = ind_hit;
      end
      default: rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= COUNT_RESET;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdata_r <= rd_data;
      rresp_r <= rd_resp;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule : tx_stats_counters

// ===== hdl/tx_stats_pkg.sv
package tx_stats_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned STRB_W     = DATA_W / 8;
  localparam int unsigned NUM_CNT    = 4;
  localparam int unsigned IND_W      = 12;

  typedef logic [DATA_W-1:0] count_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [IND_W-1:0]  ind_addr_t;
  typedef logic [7:0]        byte_t;
  typedef logic [1:0]        resp_t;

  // transmit events, one-cycle pulses from the mac datapath
  typedef struct packed {
    logic underrun_abort;
    logic good_byte_sent;
    logic byte_sent;
    logic frame_sent;
  } tx_events_t;

  // all four counter values
  typedef struct packed {
    count_t underrun_abort_bits;
    count_t good_bytes_sent_bits;
    count_t bytes_sent_bits;
    count_t frames_sent_bits;
  } tx_counts_t;

  // counter slots
  localparam int unsigned SLOT_FRAMES   = 0;
  localparam int unsigned SLOT_BYTES    = 1;
  localparam int unsigned SLOT_GOOD     = 2;
  localparam int unsigned SLOT_UNDERRUN = 3;

  // register byte addresses
  localparam addr_t FRAMES_SENT_COUNT_OFS     = 12'h300;
  localparam addr_t BYTES_SENT_COUNT_OFS      = 12'h308;
  localparam addr_t GOOD_BYTES_SENT_COUNT_OFS = 12'h30C;
  localparam addr_t UNDERRUN_ABORT_COUNT_OFS  = 12'h334;
  localparam addr_t IND_ADDR_OFS              = 12'h400;
  localparam addr_t IND_DATA_OFS              = 12'h404;

  localparam count_t    COUNT_RESET    = 32'h0000_0000;
  localparam count_t    COUNT_ONE      = 32'h0000_0001;
  localparam ind_addr_t IND_ADDR_RESET = 12'h000;
  localparam int unsigned IND_HIT_BIT  = 8;
  localparam int unsigned WORD_LSB     = 2;

  localparam resp_t RESP_OKAY   = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;

endpackage : tx_stats_pkg

// ===== hdl/event_counter.sv
`timescale 1ns/100ps
module event_counter
  import tx_stats_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   inc,
  output count_t      count
);

  count_t count_r;

  // one per event, reset only by aresetn, wraps past all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RESET;
    end else if (inc) begin
      count_r <= count_r + COUNT_ONE;
    end
  end

  assign count = count_r;

endmodule : event_counter

// ===== tb/tx_stats_chk.sv
`timescale 1ns/100ps
module tx_stats_chk
  import tx_stats_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire tx_events_t tx_events,
  input wire tx_counts_t tx_counts,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire addr_t      s_axi_araddr,
  input wire logic       s_axi_rvalid,
  input wire count_t     s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  frames_step_a: assert property ($past(aresetn) |->
    tx_counts.frames_sent_bits == $past(tx_counts.frames_sent_bits)
    + $past(tx_events.frame_sent)) else $error("frame count step");
  bytes_step_a: assert property ($past(aresetn) |->
    tx_counts.bytes_sent_bits == $past(tx_counts.bytes_sent_bits)
    + $past(tx_events.byte_sent)) else $error("byte count step");
  good_step_a: assert property ($past(aresetn) |->
    tx_counts.good_bytes_sent_bits == $past(tx_counts.good_bytes_sent_bits)
    + $past(tx_events.good_byte_sent)) else $error("good count step");
  underrun_step_a: assert property ($past(aresetn) |->
    tx_counts.underrun_abort_bits == $past(tx_counts.underrun_abort_bits)
    + $past(tx_events.underrun_abort)) else $error("underrun step");
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> tx_counts == '0) else $error("reset clear");
  wrap_zero_a: assert property (tx_events.byte_sent &&
    tx_counts.bytes_sent_bits == 32'hFFFFFFFF |=>
    tx_counts.bytes_sent_bits == '0) else $error("no wrap");
  read_bytes_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == BYTES_SENT_COUNT_OFS |=> s_axi_rvalid &&
    s_axi_rdata == $past(tx_counts.bytes_sent_bits)) else $error("rd bytes");
  read_good_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == GOOD_BYTES_SENT_COUNT_OFS |=> s_axi_rvalid &&
    s_axi_rdata == $past(tx_counts.good_bytes_sent_bits))
    else $error("rd good");
  read_undr_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == UNDERRUN_ABORT_COUNT_OFS |=> s_axi_rvalid &&
    s_axi_rdata == $past(tx_counts.underrun_abort_bits))
    else $error("rd undr");
  cover property (tx_events == 4'hF);
  cover property (s_axi_arvalid && s_axi_arready);
  cover property (tx_events.underrun_abort);
endmodule : tx_stats_chk

bind tx_stats_counters tx_stats_chk i_tx_stats_chk (.aclk(aclk),
  .aresetn(aresetn), .tx_events(tx_events), .tx_counts(tx_counts),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata));

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import tx_stats_pkg::*;
;
  logic       aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic       s_axi_rvalid;
  addr_t      s_axi_awaddr, s_axi_araddr;
  count_t     s_axi_wdata, s_axi_rdata;
  resp_t      s_axi_bresp, s_axi_rresp;
  tx_events_t tx_events;
  tx_counts_t tx_counts, exp_c;
  int         n_errors, checks_done;
  addr_t      ofs [4];
  count_t     rd_got;

  tx_stats_counters i_tx_stats_counters (.aclk(aclk), .aresetn(aresetn),
    .tx_events(tx_events), .tx_counts(tx_counts),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask : tmo

  task automatic wr(input addr_t a, input count_t d, input resp_t er);
    bit da, dw;
    int n;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    for (n = 0; n < 50 && !(da && dw); n++) begin
      @(negedge aclk);
      da |= s_axi_awready;
      dw |= s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (s_axi_bvalid === 1'b1) break;
    end
    tmo(n);
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input addr_t a, input count_t ex, input resp_t er);
    int n;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (s_axi_arready === 1'b1) break;
    end
    tmo(n);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (s_axi_rvalid === 1'b1) break;
    end
    tmo(n);
    chk(s_axi_rdata, ex);
    chk(s_axi_rresp, er);
    rd_got = s_axi_rdata;
    @(posedge aclk);
  endtask : rd

  task automatic ev(input tx_events_t e);
    @(posedge aclk);
    tx_events <= e;
    exp_c.frames_sent_bits += e.frame_sent;
    exp_c.bytes_sent_bits += e.byte_sent;
    exp_c.good_bytes_sent_bits += e.good_byte_sent;
    exp_c.underrun_abort_bits += e.underrun_abort;
  endtask : ev

  task automatic rd_all();
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], exp_c[32*k +: 32], RESP_OKAY);
    end
  endtask : rd_all

  initial begin
    int i, k, b;
    count_t t0;
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    tx_events = '0;
    exp_c = '0;
    n_errors = 0;
    checks_done = 0;
    ofs = '{FRAMES_SENT_COUNT_OFS, BYTES_SENT_COUNT_OFS,
            GOOD_BYTES_SENT_COUNT_OFS, UNDERRUN_ABORT_COUNT_OFS};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_all();
    for (i = 0; i < 40; i++) begin
      ev({i % 7 == 0, i[0], 1'b1, i % 10 == 9});
    end
    ev('0);
    @(negedge aclk);
    chk(tx_counts, exp_c);
    rd_all();
    rd(BYTES_SENT_COUNT_OFS, exp_c.bytes_sent_bits, RESP_OKAY);
    t0 = rd_got;
    repeat (5) ev(4'hF);
    ev('0);
    rd(BYTES_SENT_COUNT_OFS, exp_c.bytes_sent_bits, RESP_OKAY);
    chk(count_t'(rd_got - t0), 32'h0000_0005);
    wr(BYTES_SENT_COUNT_OFS, 32'h0000FFFF, RESP_OKAY);
    rd_all();
    for (k = 0; k < 4; k++) begin
      for (b = 0; b < 4; b++) begin
        wr(IND_ADDR_OFS, 32'(ofs[k]) + 32'(b), RESP_OKAY);
        rd(IND_DATA_OFS, {23'h0, 1'b1, exp_c[32*k+24-8*b +: 8]},
           RESP_OKAY);
      end
    end
    wr(12'h0F0, '0, RESP_SLVERR);
    rd(12'h0F0, '0, RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    ev(4'hF);
    ev('0);
    aresetn <= 1'b1;
    exp_c = '0;
    rd_all();
    end_sim();
  end

  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end
endmodule : tb_top
